// File: logic/alarm_pkg.sv
package alarm_pkg;

    // core clock and interrupt pulse timing
    localparam int CLK_PERIOD_NS   = 25;
    localparam int ALERT_PULSE_NS  = 1000;
    // least time, so round up to whole cycles
    localparam int ALERT_PULSE_CYC =
        (ALERT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_W         = 6;

    localparam int LANES           = 12;
    localparam int FLAG_W          = 16;
    localparam int SYNC_W          = 20;
    // edges the pin synchroniser needs to refill after reset
    localparam int STRAP_WAIT_CYC  = 2;

    // management bus target address
    localparam logic [6:0] DEV_ADDR = 7'h50;

    // register pointers on the management bus
    localparam logic [7:0] REG_SUMMARY = 8'h00;
    localparam logic [7:0] REG_TX_LO   = 8'h01;
    localparam logic [7:0] REG_TX_HI   = 8'h02;
    localparam logic [7:0] REG_RX_LO   = 8'h03;
    localparam logic [7:0] REG_RX_HI   = 8'h04;

    // summary byte: bit 7 engine type, bits 3:0 module flags
    localparam int SUM_RX_BIT = 7;

    // clear masks over the flat flag vector
    localparam logic [15:0] CLR_SUMMARY = 16'h000f;
    localparam logic [15:0] CLR_LANE_LO = 16'h0ff0;
    localparam logic [15:0] CLR_LANE_HI = 16'hf000;
    localparam logic [15:0] FLAGS_RST   = 16'h0000;

    // flat order: [15:4] lanes, [3] temp high, [2] temp low,
    // [1] vcc high, [0] vcc low
    typedef struct packed {
        logic [11:0] lane_flag;
        logic        temp_high;
        logic        temp_low;
        logic        vcc_high;
        logic        vcc_low;
    } alarm_vec_s;

    // management bus target states, gray along the usual path
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_ADDR     = 3'b001,
        ST_ADDR_ACK = 3'b011,
        ST_PTR      = 3'b010,
        ST_PTR_ACK  = 3'b110,
        ST_RD       = 3'b111,
        ST_RD_ACK   = 3'b101
    } mgmt_state_e;

    // read byte for a pointer; other direction reads as zero
    function automatic logic [7:0] reg_byte(input logic [7:0] p,
                                            input alarm_vec_s f,
                                            input logic       rx);
        logic [7:0] b;
        b = 8'h00;
        case (p)
            REG_SUMMARY: b = {rx, 3'h0, f.temp_high, f.temp_low,
                              f.vcc_high, f.vcc_low};
            REG_TX_LO:   b = rx ? 8'h00 : f.lane_flag[7:0];
            REG_TX_HI:   b = rx ? 8'h00 : {4'h0, f.lane_flag[11:8]};
            REG_RX_LO:   b = rx ? f.lane_flag[7:0] : 8'h00;
            REG_RX_HI:   b = rx ? {4'h0, f.lane_flag[11:8]} : 8'h00;
            default:     b = 8'h00;
        endcase
        return b;
    endfunction

    // flags cleared by reading a pointer
    function automatic logic [15:0] clr_mask(input logic [7:0] p,
                                             input logic       rx);
        logic [15:0] m;
        m = 16'h0000;
        case (p)
            REG_SUMMARY: m = CLR_SUMMARY;
            REG_TX_LO:   m = rx ? 16'h0000 : CLR_LANE_LO;
            REG_TX_HI:   m = rx ? 16'h0000 : CLR_LANE_HI;
            REG_RX_LO:   m = rx ? CLR_LANE_LO : 16'h0000;
            REG_RX_HI:   m = rx ? CLR_LANE_HI : 16'h0000;
            default:     m = 16'h0000;
        endcase
        return m;
    endfunction

endpackage

// File: logic/sync2.sv
`timescale 1ns/10ps
`default_nettype none

module sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // first stage is read by the second stage only
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

`default_nettype wire

// File: logic/optical_engine_alarm_flags.sv
`timescale 1ns/10ps
`default_nettype none

module optical_engine_alarm_flags (
    input  wire logic                 core_clk,
    input  wire logic                 rstn,
    input  wire alarm_pkg::alarm_vec_s cond_raw,
    input  wire logic                 engine_is_rx,
    input  wire logic                 module_sel_n,
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    output var  logic                 sda_out,
    output var  logic                 sda_oe,
    output var  logic                 alert_pulse_n,
    output var  alarm_pkg::alarm_vec_s flags,
    output var  logic                 engine_rx
);
    import alarm_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [SYNC_W-1:0] sync_vec;
    alarm_vec_s        cond_s;
    logic              rx_s;
    logic              sel_n_s;
    logic              scl_s;
    logic              sda_s;

    sync2 #(.WIDTH(SYNC_W)) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in ({cond_raw, engine_is_rx, module_sel_n, scl_in, sda_in}),
        .sync_out (sync_vec)
    );

    // unpack synchronised pins
    assign cond_s  = alarm_vec_s'(sync_vec[19:4]);
    assign rx_s    = sync_vec[3];
    assign sel_n_s = sync_vec[2];
    assign scl_s   = sync_vec[1];
    assign sda_s   = sync_vec[0];

    ////////////////////////////////////////////////////////////////////
    // engine type strap
    logic       strap_done_q;
    logic [1:0] strap_wait_q;
    logic       rx_q;

    // reset flushes the synchroniser, so let it refill before taking
    // the strap; otherwise every engine would read as a transmitter
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            strap_done_q <= 1'b0;
            strap_wait_q <= '0;
            rx_q         <= 1'b0;
        end else if (strap_wait_q != 2'(STRAP_WAIT_CYC)) begin
            strap_wait_q <= strap_wait_q + 2'd1;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            rx_q         <= rx_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // alarm flags
    mgmt_state_e st_q;
    logic [7:0]  ptr_q;
    logic        ld;
    logic [15:0] clr_vec;
    logic [15:0] set_vec;
    logic [15:0] flags_flat;
    logic        new_event;
    assign set_vec    = 16'(cond_s);
    assign flags_flat = 16'(flags);
    assign clr_vec    = ld ? clr_mask(ptr_q, rx_q) : 16'h0000;
    // only a flag going from clear to set counts as a new alarm
    assign new_event  = |(set_vec & ~flags_flat);
    // sticky flags, clear on read; a set in the clear cycle wins
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            flags <= alarm_vec_s'(FLAGS_RST);
        end else begin
            flags <= alarm_vec_s'((flags_flat & ~clr_vec) | set_vec);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt pulse
    logic [PULSE_W-1:0] pulse_cnt_q;
    logic [PULSE_W-1:0] pulse_cnt_d;
    // a new alarm during a pulse restarts it rather than being lost
    always_comb begin
        if (new_event) begin
            pulse_cnt_d = PULSE_W'(ALERT_PULSE_CYC);
        end else if (pulse_cnt_q != '0) begin
            pulse_cnt_d = pulse_cnt_q - PULSE_W'(1);
        end else begin
            pulse_cnt_d = '0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pulse_cnt_q   <= '0;
            alert_pulse_n <= 1'b1;
            engine_rx     <= 1'b0;
        end else begin
            pulse_cnt_q   <= pulse_cnt_d;
            alert_pulse_n <= (pulse_cnt_d == '0);
            engine_rx     <= rx_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // management bus target
    logic       scl_p_q;
    logic       sda_p_q;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic       rw_q;
    logic       nack_q;
    logic [7:0] rd_byte;
    assign rise    = scl_s & ~scl_p_q;
    assign fall    = ~scl_s & scl_p_q;
    assign start   = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop    = scl_s & scl_p_q & ~sda_p_q & sda_s;
    assign rd_byte = reg_byte(ptr_q, flags, rx_q);
    // a byte is loaded for the host at these falls
    assign ld = fall && !start && !stop &&
                ((st_q == ST_ADDR_ACK && rw_q) ||
                 (st_q == ST_RD_ACK && !nack_q));
    // previous line levels for edge and condition detection
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            sda_out <= 1'b0;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            sda_out <= 1'b0; // open drain: only ever pulls low
        end
    end

    // byte engine; data changes only after scl falls
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_q   <= ST_IDLE;
            cnt_q  <= '0;
            sh_q   <= '0;
            tx_q   <= '0;
            ptr_q  <= REG_SUMMARY;
            rw_q   <= 1'b0;
            nack_q <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop) begin
            st_q   <= ST_IDLE;
            sda_oe <= 1'b0;
        end else if (start) begin
            st_q   <= ST_ADDR;
            cnt_q  <= '0;
            sda_oe <= 1'b0;
        end else begin
            case (st_q)
                ST_ADDR: begin
                    if (rise) begin
                        sh_q  <= {sh_q[6:0], sda_s};
                        cnt_q <= cnt_q + 4'd1;
                    end else if (fall && cnt_q == 4'd8) begin
                        // deselected engines stay off the bus
                        if (sh_q[7:1] == DEV_ADDR && !sel_n_s) begin
                            sda_oe <= 1'b1;
                            rw_q   <= sh_q[0];
                            st_q   <= ST_ADDR_ACK;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_PTR: begin
                    if (rise) begin
                        sh_q  <= {sh_q[6:0], sda_s};
                        cnt_q <= cnt_q + 4'd1;
                    end else if (fall && cnt_q == 4'd8) begin
                        ptr_q  <= sh_q;
                        sda_oe <= 1'b1;
                        st_q   <= ST_PTR_ACK;
                    end
                end
                ST_PTR_ACK: begin
                    if (fall) begin
                        sda_oe <= 1'b0;
                        cnt_q  <= '0;
                        st_q   <= ST_PTR;
                    end
                end
                ST_RD: begin
                    if (fall) begin
                        if (cnt_q == 4'd8) begin
                            sda_oe <= 1'b0;
                            st_q   <= ST_RD_ACK;
                        end else begin
                            tx_q   <= {tx_q[6:0], 1'b0};
                            sda_oe <= ~tx_q[6];
                            cnt_q  <= cnt_q + 4'd1;
                        end
                    end
                end
                ST_ADDR_ACK, ST_RD_ACK: begin
                    if (rise) begin
                        nack_q <= sda_s;
                    end
                    if (ld) begin
                        tx_q   <= rd_byte;
                        sda_oe <= ~rd_byte[7];
                        cnt_q  <= 4'd1;
                        ptr_q  <= ptr_q + 8'd1;
                        nack_q <= 1'b0;
                        st_q   <= ST_RD;
                    end else if (fall && st_q == ST_ADDR_ACK) begin
                        sda_oe <= 1'b0;
                        cnt_q  <= '0;
                        st_q   <= ST_PTR;
                    end else if (fall) begin
                        // host said no more bytes
                        sda_oe <= 1'b0;
                        st_q   <= ST_IDLE;
                    end
                end
                default: begin
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    chk_alert_on_event: assert property (
        new_event |=> !alert_pulse_n [*8])
        else $error("alarm did not pull alert low");
    chk_tx_lane_set: assert property (
        (strap_done_q && !rx_q) |=>
        ((flags.lane_flag & $past(cond_s.lane_flag))
         == $past(cond_s.lane_flag)))
        else $error("emitter fault not latched");
    chk_rx_lane_set: assert property (
        (strap_done_q && rx_q && cond_s.lane_flag[11]) |=>
        flags.lane_flag[11])
        else $error("light loss not latched");
    chk_temp_flags: assert property (
        (cond_s.temp_high || cond_s.temp_low) |=>
        (flags.temp_high || flags.temp_low))
        else $error("temperature flag missing");
    chk_vcc_flags: assert property (
        cond_s.vcc_low |=> flags.vcc_low)
        else $error("supply flag missing");
    chk_flag_held: assert property (
        (flags.vcc_high && !clr_vec[1]) |=> flags.vcc_high)
        else $error("flag dropped without a read");
    chk_select_gate: assert property (
        (st_q == ST_ADDR && sel_n_s && !start && !stop) |=>
        !(st_q == ST_ADDR_ACK))
        else $error("deselected engine answered");
    chk_summary_read: assert property (
        (ld && ptr_q == REG_SUMMARY) |=>
        (tx_q[3:0] == $past(flags_flat[3:0])) && (ptr_q == 8'h01))
        else $error("summary byte wrong");
    chk_dir_split: assert property (
        (ld && rx_q && ptr_q == REG_TX_LO) |=> (tx_q == 8'h00))
        else $error("receiver showed transmitter lanes");

endmodule

`default_nettype wire

// File: tb/mgmt_host.sv
`timescale 1ns/10ps
`default_nettype none

// bit-banged host on the management bus, 200 ns per bit
module mgmt_host
    import alarm_pkg::*;
(
    output var  logic scl,
    output var  logic sda_drv,
    input  wire logic sda
);
    import alarm_pkg::*;

    // idle with both lines released
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // data moves only while the clock is low, sampled mid high phase
    task automatic bit_io(input logic b, output logic s);
        sda_drv = b;
        #100 scl = 1'b1;
        #50 s = sda;
        #50 scl = 1'b0;
    endtask

    // eight bits msb first, then the ninth (acknowledge) bit
    task automatic xfer(input logic [7:0] dat, output logic [7:0] q,
                        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(dat[i], q[i]);
        end
        bit_io(1'b1, ack);
    endtask

    // pointer write, repeated start, one byte read with nack, stop
    task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] q,
                          output logic acked);
        logic [7:0] junk;
        logic       a0;
        logic       a1;
        logic       a2;
        logic       a3;
        sda_drv = 1'b0;
        #100 scl = 1'b0;
        #50;
        xfer({DEV_ADDR, 1'b0}, junk, a0);
        xfer(ptr, junk, a1);
        // wait out the target's ack before raising the clock again
        sda_drv = 1'b1;
        #100 scl = 1'b1;
        #50 sda_drv = 1'b0;
        #50 scl = 1'b0;
        xfer({DEV_ADDR, 1'b1}, junk, a2);
        xfer(8'hff, q, a3);
        sda_drv = 1'b0;
        #100 scl = 1'b1;
        #50 sda_drv = 1'b1;
        #100;
        acked = !a0 && !a1 && !a2;
    endtask
endmodule
`default_nettype wire

// File: tb/optical_engine_alarm_flags_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module optical_engine_alarm_flags_tb_top;
    import alarm_pkg::*;

    logic        core_clk;
    logic        rstn;
    alarm_vec_s  cond_raw;
    logic        engine_is_rx;
    logic        module_sel_n;
    logic        scl;
    logic        sda_drv;
    wire logic   sda;
    logic        sda_out;
    logic        sda_oe;
    logic        alert_pulse_n;
    alarm_vec_s  flags;
    logic        engine_rx;
    int          mismatches = 0;
    int          n_compared = 0;
    int          pulses = 0;
    int          width = 0;
    int          low_cnt = 0;
    logic [15:0] mflags;
    logic [7:0]  lfsr;

    ////////////////////////////////////////////////////////////////////
    // open drain line with pull-up: low if anyone pulls
    assign sda = sda_drv && !(sda_oe && !sda_out);

    optical_engine_alarm_flags dut (
        .core_clk      (core_clk),
        .rstn          (rstn),
        .cond_raw      (cond_raw),
        .engine_is_rx  (engine_is_rx),
        .module_sel_n  (module_sel_n),
        .scl_in        (scl),
        .sda_in        (sda),
        .sda_out       (sda_out),
        .sda_oe        (sda_oe),
        .alert_pulse_n (alert_pulse_n),
        .flags         (flags),
        .engine_rx     (engine_rx)
    );

    mgmt_host host (
        .scl     (scl),
        .sda_drv (sda_drv),
        .sda     (sda)
    );

    // free running core clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // length and count of each low pulse on the alert line
    always @(posedge core_clk) begin
        if (alert_pulse_n === 1'b0) begin
            low_cnt <= low_cnt + 1;
        end else if (low_cnt != 0) begin
            pulses <= pulses + 1;
            width <= low_cnt;
            low_cnt <= 0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic fail(input string m);
        mismatches++;
        $display("[ERR] %0t %s", $time, m);
    endtask

    task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) fail($sformatf("byte %h want %h", g, e));
    endtask

    task automatic cmp_flags(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) fail($sformatf("flags %h want %h", g, e));
    endtask

    task automatic cmp_bit(input logic g, input logic e);
        n_compared++;
        if (g !== e) fail("single bit output wrong");
    endtask

    task automatic cmp_int(input int g, input int e);
        n_compared++;
        if (g != e) fail($sformatf("pulse figure %0d want %0d", g, e));
    endtask

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // reference byte from the model, which it then clears
    task automatic read_check(input logic [7:0] ptr, input logic rx);
        logic [7:0] q;
        logic       ack;
        logic [7:0] e;
        e = 8'h00;
        if (ptr == REG_SUMMARY) begin
            e = {rx, 3'b000, mflags[3:0]};
            mflags[3:0] = 4'h0;
        end else if (ptr == (rx ? REG_RX_LO : REG_TX_LO)) begin
            e = mflags[11:4];
            mflags[11:4] = 8'h00;
        end else if (ptr == (rx ? REG_RX_HI : REG_TX_HI)) begin
            e = {4'h0, mflags[15:12]};
            mflags[15:12] = 4'h0;
        end
        host.rd_reg(ptr, q, ack);
        cmp_bit(ack, 1'b1);
        cmp_byte(q, e);
    endtask

    // strap must be steady well before release
    task automatic do_reset(input logic rx);
        @(negedge core_clk);
        rstn = 1'b0;
        engine_is_rx = rx;
        repeat (20) @(negedge core_clk);
        rstn = 1'b1;
        repeat (4) @(negedge core_clk);
        mflags = 16'h0000;
        cmp_flags(flags, 16'h0000);
        cmp_bit(alert_pulse_n, 1'b1);
        cmp_bit(sda_oe, 1'b0);
        cmp_bit(engine_rx, rx);
    endtask

    // raise a condition pattern briefly, then let the pulse finish
    task automatic raise(input logic [15:0] p);
        cond_raw = p;
        repeat (4) @(negedge core_clk);
        cond_raw = '0;
        repeat (50) @(negedge core_clk);
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // both engine types, random alarm patterns, read back and clear
    initial begin
        logic [15:0] p;
        int          p0;
        logic [7:0]  q;
        logic        ack;
        rstn = 1'b0;
        cond_raw = '0;
        engine_is_rx = 1'b0;
        module_sel_n = 1'b0;
        lfsr = 8'd94;
        for (int rx = 0; rx < 2; rx++) begin
            do_reset(rx[0]);
            for (int it = 0; it < 6; it++) begin
                lfsr = lfsr_next(lfsr);
                p[15:8] = lfsr;
                lfsr = lfsr_next(lfsr);
                p[7:0] = (lfsr == 8'h00) ? 8'h01 : lfsr;
                p0 = pulses;
                raise(p);
                mflags = p;
                cmp_int(pulses, p0 + 1);
                cmp_int(width, ALERT_PULSE_CYC);
                cmp_flags(flags, mflags);
                // already latched: no fresh pulse expected
                raise(p);
                cmp_int(pulses, p0 + 1);
                // deselected engine stays silent and keeps its flags
                module_sel_n = 1'b1;
                host.rd_reg(REG_SUMMARY, q, ack);
                cmp_bit(ack, 1'b0);
                cmp_flags(flags, mflags);
                module_sel_n = 1'b0;
                repeat (4) @(negedge core_clk);
                for (int r = 0; r < 6; r++) begin
                    read_check(r[7:0], rx[0]);
                end
                cmp_flags(flags, mflags);
            end
        end
        test_done();
    end

    // cut a hang well past the expected run of under 1 ms
    initial begin
        #2_000_000;
        fail("watchdog expired");
        test_done();
    end
endmodule
`default_nettype wire
